//--- logic/adcsq_pkg.sv
/*
 * Package for the 8-bit converter sequencer: register offsets, field
 * positions, reset values, timing counts and the analog-side carriers.
 * Assumes a single 100 MHz clock and an APB register bus.
 */
package adcsq_pkg;

    // Printed offsets 0Ah and 0Bh are not multiples of four: they are indices.
    localparam logic [7:0] IDX_RESULT = 8'h0a;
    localparam logic [7:0] IDX_CTRL = 8'h0b;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] IDX_IRQ_ENABLE = 8'h0d;
    localparam logic [7:0] IDX_IRQ_CLEAR = 8'h0e;
    localparam logic [11:0] ADDR_RESULT = {2'h0, IDX_RESULT, 2'h0};
    localparam logic [11:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
    localparam logic [11:0] ADDR_IRQ_STATUS = {2'h0, IDX_IRQ_STATUS, 2'h0};
    localparam logic [11:0] ADDR_IRQ_ENABLE = {2'h0, IDX_IRQ_ENABLE, 2'h0};
    localparam logic [11:0] ADDR_IRQ_CLEAR = {2'h0, IDX_IRQ_CLEAR, 2'h0};

    localparam int BIT_DONE = 7;
    localparam int BIT_ON = 5;
    localparam int CH_MSB = 3;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [3:0] CH_MAX = 4'hb;

    // Interrupt status bits (events of this block).
    localparam int EV_DONE = 0;
    localparam int EV_ABORT = 1;
    localparam int EV_BAD_CH = 2;
    localparam int EV_W = 3;

    // Converter clock is one quarter of mclk; a conversion is 12 of them.
    localparam int CPU_PER_ADC = 4;
    localparam int ADC_PER_CONV = 12;
    localparam int LOAD_ADC = 4;
    localparam int STEPS = 8;
    localparam logic [1:0] DIV_LAST = 2'(CPU_PER_ADC - 1);
    localparam logic [3:0] LOAD_LAST = 4'(LOAD_ADC - 1);
    localparam logic [3:0] CONV_LAST = 4'(ADC_PER_CONV - 1);

    typedef enum logic [1:0] {
        ADCSQ_OFF = 2'b00,
        ADCSQ_LOAD = 2'b01,
        ADCSQ_CONV = 2'b10
    } adcsq_state_t;

    // Drive toward the analog core.
    typedef struct packed {
        logic power;
        logic sample;
        logic [3:0] channel;
        logic [7:0] trial;
    } adcsq_ana_ctl_t;

endpackage : adcsq_pkg

//--- logic/adcsq_top.sv
/*
 * Sequencer for an 8-bit successive-approximation converter with APB
 * registers, a result register and an interrupt unit of its own.
 * Assumes the analog core compares its held sample against the trial code
 * and answers with comp_hi (sample at or above trial); that answer and the
 * halt request arrive from outside the clock domain.
 */
`timescale 1ns/10ps
module adcsq_top
    import adcsq_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic comp_hi,
    input wire logic halt_req,
    input wire logic [11:0] ain_pin,
    output adcsq_ana_ctl_t ana_ctl,
    output logic [11:0] ain_logic,
    output logic irq
);

    logic [1:0] comp_sync;
    logic [1:0] halt_sync;
    logic [11:0] pin_s1;
    logic [11:0] pin_s2;
    logic conv_on;
    logic [3:0] channel;
    logic done_flag;
    logic [7:0] result;
    logic [7:0] sar;
    logic [2:0] step;
    logic [1:0] div;
    logic [3:0] tick;
    adcsq_state_t state;
    logic [EV_W-1:0] irq_status;
    logic [EV_W-1:0] irq_enable;
    logic setup;
    logic access;
    logic wr_ctrl;
    logic rd_result;
    logic wr_clear;
    logic wr_enable;
    logic adc_edge;
    logic finish;
    logic restart;
    logic active;
    logic [7:0] next_sar;

    // The halt line and comparator come from other domains.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            comp_sync <= 2'h0;
            halt_sync <= 2'h0;
            pin_s1 <= 12'h000;
            pin_s2 <= 12'h000;
        end else begin
            comp_sync <= {comp_sync[0], comp_hi};
            halt_sync <= {halt_sync[0], halt_req};
            pin_s1 <= ain_pin;
            pin_s2 <= pin_s1;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ain_logic <= 12'h000;
        end else begin
            ain_logic <= pin_s2;
        end
    end

    // Every access completes in its first access cycle; no wait states.
    // Read data is registered at the setup edge, but writes and the
    // read side effect land only at the access edge where pready is high.
    assign setup = psel && !penable;
    assign access = psel && penable && pready;
    assign wr_ctrl = access && pwrite && paddr == ADDR_CTRL;
    assign rd_result = access && !pwrite && paddr == ADDR_RESULT;
    assign wr_clear = access && pwrite && paddr == ADDR_IRQ_CLEAR;
    assign wr_enable = access && pwrite && paddr == ADDR_IRQ_ENABLE;

    function automatic logic mapped(input logic [11:0] a);
        return a == ADDR_RESULT || a == ADDR_CTRL || a == ADDR_IRQ_STATUS ||
            a == ADDR_IRQ_ENABLE || a == ADDR_IRQ_CLEAR;
    endfunction : mapped

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped(paddr);
            prdata <= 32'h0000_0000;
            if (setup && !pwrite) begin
                unique case (paddr)
                    ADDR_RESULT: prdata <= {24'h000000, result};
                    ADDR_CTRL: prdata <= {24'h000000, done_flag, 1'b0,
                        conv_on, 1'b0, channel};
                    ADDR_IRQ_STATUS: prdata <= {29'h0, irq_status};
                    ADDR_IRQ_ENABLE: prdata <= {29'h0, irq_enable};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            conv_on <= CTRL_RESET[BIT_ON];
            channel <= CTRL_RESET[CH_MSB:0];
        end else if (wr_ctrl) begin
            conv_on <= pwdata[BIT_ON];
            channel <= pwdata[CH_MSB:0];
        end
    end

    // no wait input; halt gates power without touching registers.
    assign active = conv_on && !halt_sync[1];
    assign adc_edge = div == DIV_LAST;
    assign finish = state == ADCSQ_CONV && adc_edge && tick == CONV_LAST;
    assign restart = wr_ctrl && pwdata[BIT_ON];

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            div <= 2'h0;
        end else if (state == ADCSQ_OFF || restart) begin
            div <= 2'h0;
        end else begin
            div <= div + 2'h1;
        end
    end

    always_comb begin
        next_sar = sar;
        if (comp_sync[1] == 1'b0) begin
            next_sar[3'd7 - step] = 1'b0;
        end
        if (step != 3'd7) begin
            next_sar[3'd6 - step] = 1'b1;
        end
    end

    // back to back; start; off; stop at once
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state <= ADCSQ_OFF;
            tick <= 4'h0;
            step <= 3'h0;
            sar <= 8'h80;
        end else if (!active || (wr_ctrl && !pwdata[BIT_ON])) begin
            state <= ADCSQ_OFF;
            tick <= 4'h0;
        end else if (restart || state == ADCSQ_OFF) begin
            state <= ADCSQ_LOAD;
            tick <= 4'h0;
        end else if (adc_edge) begin
            tick <= (tick == CONV_LAST) ? 4'h0 : tick + 4'h1;
            unique case (state)
                ADCSQ_LOAD: begin
                    if (tick == LOAD_LAST) begin
                        state <= ADCSQ_CONV;
                        step <= 3'h0;
                        sar <= 8'h80;
                    end
                end
                ADCSQ_CONV: begin
                    sar <= next_sar;
                    step <= step + 3'h1;
                    if (tick == CONV_LAST) begin
                        state <= ADCSQ_LOAD;
                    end
                end
                default: state <= ADCSQ_OFF;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            result <= RESULT_RESET;
        end else if (finish && active && !wr_ctrl) begin
            // The last step decides bit 0 in this very cycle.
            result <= next_sar;
        end
    end

    // done flag; clears. A finishing conversion wins over a read.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            done_flag <= CTRL_RESET[BIT_DONE];
        end else if (finish && active && !wr_ctrl) begin
            done_flag <= 1'b1;
        end else if (rd_result || wr_ctrl) begin
            done_flag <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ana_ctl <= '0;
        end else begin
            ana_ctl.power <= active;
            ana_ctl.sample <= state == ADCSQ_LOAD && active;
            ana_ctl.channel <= channel;
            ana_ctl.trial <= (state == ADCSQ_CONV) ? sar : 8'h00;
        end
    end

    // Block interrupt unit; set beats a clear in the same cycle.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            irq_status <= '0;
            irq_enable <= '0;
        end else begin
            if (wr_enable) begin
                irq_enable <= pwdata[EV_W-1:0];
            end
            irq_status <= (irq_status & ~({EV_W{wr_clear}} &
                pwdata[EV_W-1:0])) | {wr_ctrl && pwdata[CH_MSB:0] > CH_MAX,
                wr_ctrl && conv_on && state != ADCSQ_OFF,
                finish && active && !wr_ctrl};
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_enable);
        end
    end

endmodule : adcsq_top

//--- tb/adcsq_core_model.sv
/* Behavioural analog multiplexer and converter core.
   Assumes ana_ctl comes from the sequencer, registered on mclk. */
`timescale 1ns/10ps
module adcsq_core_model
    import adcsq_pkg::*;
(
    input wire logic mclk,
    input wire adcsq_ana_ctl_t ana_ctl,
    input wire logic [95:0] levels,
    output logic comp_hi
);
    logic [7:0] held;
    logic last = 1'b0;
    always_ff @(posedge mclk) begin
        if (ana_ctl.sample) begin
            held <= levels[8*ana_ctl.channel +: 8];
        end
        last <= comp_hi;
    end
    // unsigned compare: held at or above trial.
    // Unpowered, the answer toggles so a stale level is never trusted.
    assign comp_hi = ana_ctl.power ? (held >= ana_ctl.trial) : ~last;
endmodule : adcsq_core_model

//--- tb/adcsq_properties.sv
/* Port checker for adcsq_top.
   Bound from the testbench top; sees only the top module ports. */
`timescale 1ns/10ps
module adcsq_checker
    import adcsq_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic halt_req,
    input wire logic [11:0] ain_pin,
    input wire logic [11:0] ain_logic,
    input wire adcsq_ana_ctl_t ana_ctl
);
    logic mapped;
    assign mapped = paddr inside {ADDR_RESULT, ADDR_CTRL, ADDR_IRQ_STATUS,
        ADDR_IRQ_ENABLE, ADDR_IRQ_CLEAR};
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_load;
        $rose(ana_ctl.sample) && !psel ##1 (!psel && !halt_req)[*7];
    endsequence
    a_ready_next: assert property (s_setup |=> pready)
        else $error("no pready after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_map: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr disagrees with address map");
    a_halt_off: assert property (halt_req[*6] |-> !ana_ctl.power)
        else $error("converter powered during halt");
    a_pin_copy: assert property ($changed(ain_logic)
        |-> ain_logic == $past(ain_pin, 3)) else $error("pin copy wrong");
    a_sample_pow: assert property (ana_ctl.sample |-> ana_ctl.power)
        else $error("sampling while unpowered");
    a_load_hold: assert property (s_load |-> ana_ctl.sample)
        else $error("load phase cut short");
    a_chan_hold: assert property (ana_ctl.sample && $past(ana_ctl.sample)
        && !$past(psel) && !$past(psel, 2) |-> $stable(ana_ctl.channel))
        else $error("channel moved while loading");
endmodule : adcsq_checker

//--- tb/tb.sv
/* Self-checking bench for adcsq_top with the analog core model.
   Drives APB on mclk rising edges; binds the port checker. */
`timescale 1ns/10ps
module tb
    import adcsq_pkg::*;
;
    logic mclk, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic halt_req = 1'b0, pready, pslverr, comp_hi, irq, err;
    logic [11:0] paddr = 12'h0, ain_pin = 12'h0, ain_logic;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [95:0] levels = 96'h0;
    adcsq_ana_ctl_t ana_ctl;
    int mismatches = 0, samples_checked = 0, cyc = 0, c0;
    adcsq_top uut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .comp_hi(comp_hi),
        .halt_req(halt_req), .ain_pin(ain_pin), .ana_ctl(ana_ctl),
        .ain_logic(ain_logic), .irq(irq));
    adcsq_core_model core (.mclk(mclk), .ana_ctl(ana_ctl), .levels(levels),
        .comp_hi(comp_hi));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) cyc++;
    task automatic test_done;
        $display("mismatches=%0d checked=%0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            mismatches++;
            test_done();
        end
        @(posedge mclk);
    endtask : apb
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdc
    task automatic wait_done;
        int n;
        n = 0;
        do begin
            apb(1'b0, ADDR_CTRL, 32'h0);
            n++;
        end while (rd[BIT_DONE] !== 1'b1 && n < 60);
        if (n >= 60) begin
            mismatches++;
            test_done();
        end
    endtask : wait_done
    task automatic t_chan;
        logic [7:0] lv;
        for (int ch = 0; ch < 12; ch++) begin
            lv = (ch == 11) ? 8'hff : 8'(ch * 8'h15);
            levels[8*ch +: 8] <= lv;
            apb(1'b1, ADDR_CTRL, 32'(8'h20 | ch));
            c0 = cyc;
            wait_done();
            chk(32'(cyc - c0 inside {[46:54]}), 32'h1);
            chk(rd, 32'(8'ha0 | ch));
            rdc(ADDR_RESULT, {24'h0, lv});
            rdc(ADDR_CTRL, 32'(8'h20 | ch));
        end
        apb(1'b1, ADDR_CTRL, 32'h0);
    endtask : t_chan
    task automatic t_abort;
        levels[47:40] <= 8'h77;
        apb(1'b1, ADDR_CTRL, 32'h25);
        wait_done();
        repeat (20) @(posedge mclk);
        apb(1'b1, ADDR_CTRL, 32'h25);
        c0 = cyc;
        rdc(ADDR_CTRL, 32'h25);
        wait_done();
        chk(32'(cyc - c0 inside {[46:54]}), 32'h1);
        rdc(ADDR_RESULT, 32'h77);
        wait_done();
        repeat (20) @(posedge mclk);
        levels[47:40] <= 8'h11;
        apb(1'b1, ADDR_CTRL, 32'h05);
        repeat (120) @(posedge mclk);
        chk(ana_ctl.power, 1'b0);
        rdc(ADDR_CTRL, 32'h05);
        rdc(ADDR_RESULT, 32'h77);
    endtask : t_abort
    task automatic t_halt;
        apb(1'b1, ADDR_CTRL, 32'h25);
        repeat (10) @(posedge mclk);
        halt_req <= 1'b1;
        repeat (100) @(posedge mclk);
        chk(ana_ctl.power, 1'b0);
        rdc(ADDR_CTRL, 32'h25);
        halt_req <= 1'b0;
        wait_done();
        rdc(ADDR_RESULT, 32'h11);
        apb(1'b1, ADDR_CTRL, 32'h0);
    endtask : t_halt
    task automatic t_irq;
        apb(1'b1, ADDR_IRQ_CLEAR, 32'h7);
        apb(1'b1, ADDR_IRQ_ENABLE, 32'h1);
        apb(1'b1, ADDR_CTRL, 32'h0c);
        rdc(ADDR_IRQ_STATUS, 32'h4);
        chk(irq, 1'b0);
        apb(1'b1, ADDR_CTRL, 32'h21);
        wait_done();
        chk(irq, 1'b1);
        apb(1'b1, ADDR_CTRL, 32'h01);
        rdc(ADDR_IRQ_STATUS, 32'h7);
        apb(1'b1, ADDR_IRQ_CLEAR, 32'h7);
        @(posedge mclk);
        chk(irq, 1'b0);
        rdc(ADDR_IRQ_STATUS, 32'h0);
    endtask : t_irq
    initial begin
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        rdc(ADDR_CTRL, {24'h0, CTRL_RESET});
        rdc(ADDR_RESULT, {24'h0, RESULT_RESET});
        rdc(12'h03c, 32'h0);
        chk(err, 1'b1);
        ain_pin <= 12'ha5c;
        repeat (5) @(posedge mclk);
        chk(ain_logic, 12'ha5c);
        t_chan();
        t_abort();
        t_halt();
        t_irq();
        test_done();
    end
endmodule : tb
bind adcsq_top adcsq_checker u_chk (.mclk(mclk), .rstn(rstn), .psel(psel),
    .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .halt_req(halt_req), .ain_pin(ain_pin), .ain_logic(ain_logic),
    .ana_ctl(ana_ctl));
